// file: asg_cfg.svh
// Purpose: Constants of the axis-select and GPIO command block.
// Assumes: 40 MHz clock; ASCII command bytes.
// Notes:   Offsets are byte addresses on the plain register port.
`ifndef ASG_CFG_SVH
`define ASG_CFG_SVH

// Register offsets
`define ASG_REG_DIR 4'h0
`define ASG_REG_STATUS 4'h4
`define ASG_REG_PINS 4'h8

// Reset values
`define ASG_OE_N_RST 8'hff
`define ASG_OUT_RST 8'hff
`define ASG_BIPOLAR_RST 4'hf

// Status field positions
`define ASG_ST_BIPOLAR_LSB 0
`define ASG_ST_AXIS_LSB 4
`define ASG_ST_MULTI_BIT 6
`define ASG_ST_WAIT_BIT 7
`define ASG_ST_WBIT_LSB 8
`define ASG_ST_VALID_BIT 11

// Pins register field positions
`define ASG_PN_OUT_LSB 8

// Timing
`define ASG_CLK_NS 25
`define ASG_SETTLE_NS 1000
`define ASG_SETTLE_CYC ((`ASG_SETTLE_NS + `ASG_CLK_NS - 1) / `ASG_CLK_NS)

// Characters
`define ASG_CH_LF 8'h0a
`define ASG_CH_CR 8'h0d
`define ASG_CH_SPACE 8'h20
`define ASG_CH_SEMI 8'h3b
`define ASG_CH_QMARK 8'h3f
`define ASG_CH_0 8'h30
`define ASG_CH_9 8'h39
`define ASG_CH_UA 8'h41
`define ASG_CH_UF 8'h46
`define ASG_CH_UZ 8'h5a
`define ASG_CH_LA 8'h61
`define ASG_CH_LZ 8'h7a
`define ASG_CH_CASE 8'h20
`define ASG_CH_B 8'h42
`define ASG_CH_D 8'h44
`define ASG_CH_H 8'h48
`define ASG_CH_I 8'h49
`define ASG_CH_L 8'h4c
`define ASG_CH_M 8'h4d
`define ASG_CH_S 8'h53
`define ASG_CH_T 8'h54
`define ASG_CH_W 8'h57
`define ASG_CH_X 8'h58
`define ASG_CH_Y 8'h59
`define ASG_CH_Z 8'h5a
`define ASG_CH_LI 8'h69
`define ASG_CH_LO 8'h6f

`endif

// file: asg_pkg.sv
// Purpose: Types of the axis-select and GPIO command block.
// Assumes: Nothing beyond the constants header.
// Notes:   Parser states are Gray coded along the usual path.
package asg_pkg;

    // Single-axis target
    typedef enum logic [1:0] {
        asg_axis_x = 2'h0,
        asg_axis_y = 2'h1,
        asg_axis_z = 2'h2,
        asg_axis_t = 2'h3
    } asg_axis_type;

    // Parser states: collect -> exec -> reply -> collect
    typedef enum logic [1:0] {
        asg_st_collect = 2'h0,
        asg_st_exec = 2'h1,
        asg_st_reply = 2'h3
    } asg_state_type;

    // Decoded commands
    typedef enum logic [3:0] {
        asg_cmd_none = 4'h0,
        asg_cmd_sel_x = 4'h1,
        asg_cmd_sel_y = 4'h2,
        asg_cmd_sel_z = 4'h3,
        asg_cmd_sel_t = 4'h4,
        asg_cmd_multi = 4'h5,
        asg_cmd_bipolar = 4'h6,
        asg_cmd_high = 4'h7,
        asg_cmd_low = 4'h8,
        asg_cmd_mask = 4'h9,
        asg_cmd_wait_low = 4'ha,
        asg_cmd_q_dir = 4'hb,
        asg_cmd_q_state = 4'hc
    } asg_cmd_type;

endpackage

// file: asg_reply_tx.sv
// Purpose: Sends a reply of up to four bytes over a valid/ready stream.
// Assumes: start only while busy is low.
// Notes:   Byte 0 goes first; busy equals tx_valid.
`timescale 1ns/1ps
`default_nettype none

module asg_reply_tx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Reply request
    input wire logic start,
    input wire logic [2:0] len,
    input wire logic [7:0] byte0,
    input wire logic [7:0] byte1,
    input wire logic [7:0] byte2,
    input wire logic [7:0] byte3,
    output logic busy,
    // Byte stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);

    logic [23:0] rest_q;
    logic [2:0] left_q;

    ////////////////////////////////////////////////////////////////////////
    // Load on start, shift one byte per accepted transfer
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            rest_q <= 24'h000000;
            left_q <= 3'h0;
        end else if (ce) begin
            if (start && !tx_valid) begin
                tx_valid <= 1'b1;
                tx_data <= byte0;
                rest_q <= {byte3, byte2, byte1};
                left_q <= len;
            end else if (tx_valid && tx_ready) begin
                tx_data <= rest_q[7:0];
                rest_q <= {8'h00, rest_q[23:8]};
                left_q <= left_q - 3'h1;
                tx_valid <= (left_q > 3'h1); // Last byte ends the reply
            end
        end
    end

    assign busy = tx_valid;

endmodule // asg_reply_tx

`default_nettype wire

// file: asg_cmd_top.sv
// Purpose: ASCII command interpreter for axis select and eight GPIO bits.
// Assumes: Command bytes and register port are on clk; gpio_in is async.
// Notes:   Queued commands stall behind a pending wait; immediate ones run.
//
// Notes on behaviour
// [RL1] Y select routes later commands to Y
// [RL2] Z select routes later commands to Z
// [RL3] Arrival order; queued commands wait, immediate run
// [RL4] Direction query replies io0 or io1, LF
// [RL5] Bit-high drives chosen output high (off)
// [RL6] Outputs reset high (off)
// [RL7] Bit-low drives chosen output low (on)
// [RL8] Mask writes all outputs at once, bit0 right
// [RL9] Host sends two-digit hex mask 00..FF
// [RL10] Writes to input bits are ignored
// [RL11] State query replies 1 or 0, LF
// [RL12] Wait-low holds commands until input low
// [RL13] Bipolar only in single axis; reset default
// [RL14] Outputs flagged valid only after settling
// [RL15] X axis selected after reset
// [RL16] Commands end with semicolon; replies end LF
//
// The register addresses and the plain strobed port were left to the implementer.
`include "asg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module asg_cmd_top #(
    parameter int GPIO_W = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Command byte stream
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    // Reply byte stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // General-purpose pins
    input wire logic [GPIO_W-1:0] gpio_in,
    output logic [GPIO_W-1:0] gpio_out,
    output logic [GPIO_W-1:0] gpio_oe_n,
    // Axis state
    output logic [1:0] axis_sel,
    output logic multi_mode,
    output logic [3:0] servo_bipolar,
    output logic outputs_valid,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // Bit numbers 0..7 and a two-digit mask fix the width
    if (GPIO_W != 8) begin : g_width_check
        $error("asg_cmd_top: GPIO_W must be 8");
    end

    localparam logic [7:0] SETTLE_CYC = 8'(`ASG_SETTLE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Fold lower-case letters to upper case
    function automatic logic [7:0] to_upper(input logic [7:0] c);
        if (c >= `ASG_CH_LA && c <= `ASG_CH_LZ) begin
            return c - `ASG_CH_CASE;
        end
        return c;
    endfunction

    // Upper-case letter test
    function automatic logic is_letter(input logic [7:0] c);
        return (c >= `ASG_CH_UA && c <= `ASG_CH_UZ);
    endfunction

    // Hex digit value, bit 4 flags a valid digit
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= `ASG_CH_0 && c <= `ASG_CH_9) begin
            return {1'b1, 4'(c - `ASG_CH_0)};
        end
        if (c >= `ASG_CH_UA && c <= `ASG_CH_UF) begin
            return {1'b1, 4'(c - `ASG_CH_UA + 8'h0a)};
        end
        return 5'h00;
    endfunction

    // Commands that sit behind a pending wait
    function automatic logic is_queued(input asg_pkg::asg_cmd_type k);
        return (k == asg_pkg::asg_cmd_high || k == asg_pkg::asg_cmd_low ||
                k == asg_pkg::asg_cmd_mask ||
                k == asg_pkg::asg_cmd_wait_low);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    asg_pkg::asg_state_type state_q, state_d;
    asg_pkg::asg_cmd_type cmd;
    logic [GPIO_W-1:0] pin_s1_q, pin_s2_q;
    logic [GPIO_W-1:0] out_q, oe_n_q;
    logic [7:0] settle_q;
    logic qmark_q, bad_q;
    logic [7:0] c1_q, c2_q, arg_q, up;
    logic [1:0] nlet_q, ndig_q;
    logic [4:0] hv;
    logic acc, is_term, bit_ok, mask_ok, hold, fire, done;
    logic [2:0] bitn;
    logic wait_q;
    logic [2:0] wait_bit_q;
    asg_pkg::asg_axis_type axis_q;
    logic multi_q;
    logic [3:0] bipolar_q;
    logic rep_start, rep_busy;
    logic [2:0] rep_len;
    logic [7:0] rep_b0, rep_b1, rep_b2, rep_b3;

    assign up = to_upper(rx_data);
    assign hv = hex_val(up);
    assign acc = rx_valid && rx_ready;
    // [RL16] Semicolon terminator
    assign is_term = (rx_data == `ASG_CH_SEMI);
    assign bitn = arg_q[2:0];
    assign bit_ok = (ndig_q == 2'h1 || ndig_q == 2'h2) && arg_q <= 8'h07;
    // [RL9] Mask of one or two digits
    assign mask_ok = (ndig_q == 2'h1 || ndig_q == 2'h2);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, two flops before any use
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else if (ce) begin
            pin_s1_q <= gpio_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [RL14] Settle delay
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_q <= 8'h00;
            outputs_valid <= 1'b0;
        end else if (ce) begin
            if (settle_q < SETTLE_CYC) begin
                settle_q <= settle_q + 8'h01;
            end
            outputs_valid <= (settle_q >= SETTLE_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Token collection: optional '?', two letters, hex argument
    always_ff @(posedge clk) begin
        if (rst || (ce && done)) begin
            qmark_q <= 1'b0;
            bad_q <= 1'b0;
            c1_q <= 8'h00;
            c2_q <= 8'h00;
            nlet_q <= 2'h0;
            arg_q <= 8'h00;
            ndig_q <= 2'h0;
        end else if (ce && acc && !is_term) begin
            if (rx_data == `ASG_CH_SPACE || rx_data == `ASG_CH_LF ||
                rx_data == `ASG_CH_CR) begin
                qmark_q <= qmark_q; // Whitespace is skipped
            end else if (rx_data == `ASG_CH_QMARK && nlet_q == 2'h0 &&
                         !qmark_q) begin
                qmark_q <= 1'b1;
            end else if (is_letter(up) && nlet_q < 2'h2 &&
                         ndig_q == 2'h0) begin
                if (nlet_q == 2'h0) begin
                    c1_q <= up;
                end else begin
                    c2_q <= up;
                end
                nlet_q <= nlet_q + 2'h1;
            end else if (hv[4] && nlet_q == 2'h2 && ndig_q < 2'h3) begin
                arg_q <= {arg_q[3:0], hv[3:0]};
                ndig_q <= ndig_q + 2'h1;
            end else begin
                bad_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode from the collected token
    always_comb begin
        cmd = asg_pkg::asg_cmd_none;
        if (!bad_q && nlet_q == 2'h2 && !qmark_q) begin
            if (c1_q == `ASG_CH_UA) begin
                unique case (c2_q)
                    `ASG_CH_X: cmd = asg_pkg::asg_cmd_sel_x;
                    `ASG_CH_Y: cmd = asg_pkg::asg_cmd_sel_y;
                    `ASG_CH_Z: cmd = asg_pkg::asg_cmd_sel_z;
                    `ASG_CH_T: cmd = asg_pkg::asg_cmd_sel_t;
                    `ASG_CH_UA, `ASG_CH_M: cmd = asg_pkg::asg_cmd_multi;
                    default: cmd = asg_pkg::asg_cmd_none;
                endcase
            end else if (c1_q == `ASG_CH_B) begin
                unique case (c2_q)
                    `ASG_CH_I: cmd = asg_pkg::asg_cmd_bipolar;
                    `ASG_CH_H: cmd = asg_pkg::asg_cmd_high;
                    `ASG_CH_L: cmd = asg_pkg::asg_cmd_low;
                    `ASG_CH_S: cmd = asg_pkg::asg_cmd_mask;
                    `ASG_CH_W: cmd = asg_pkg::asg_cmd_wait_low;
                    default: cmd = asg_pkg::asg_cmd_none;
                endcase
            end
        end else if (!bad_q && nlet_q == 2'h2 && c1_q == `ASG_CH_B) begin
            if (c2_q == `ASG_CH_D) begin
                cmd = asg_pkg::asg_cmd_q_dir;
            end else if (c2_q == `ASG_CH_S) begin
                cmd = asg_pkg::asg_cmd_q_state;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and reply request
    // [RL3] Queued stall behind wait
    assign hold = is_queued(cmd) && wait_q;
    assign fire = (state_q == asg_pkg::asg_st_exec) && !hold;

    always_comb begin
        state_d = state_q;
        rep_start = 1'b0;
        rep_len = 3'h0;
        rep_b0 = 8'h00;
        rep_b1 = 8'h00;
        rep_b2 = 8'h00;
        rep_b3 = 8'h00;
        unique case (state_q)
            asg_pkg::asg_st_collect: begin
                if (acc && is_term) begin
                    state_d = asg_pkg::asg_st_exec;
                end
            end
            asg_pkg::asg_st_exec: begin
                if (!hold) begin
                    state_d = asg_pkg::asg_st_collect;
                end
                // [RL4] Direction reply
                if (cmd == asg_pkg::asg_cmd_q_dir && bit_ok) begin
                    rep_start = 1'b1;
                    rep_len = 3'h4;
                    rep_b0 = `ASG_CH_LI;
                    rep_b1 = `ASG_CH_LO;
                    rep_b2 = `ASG_CH_0 + {7'h00, !oe_n_q[bitn]};
                    rep_b3 = `ASG_CH_LF;
                    state_d = asg_pkg::asg_st_reply;
                end
                // [RL11] State reply
                if (cmd == asg_pkg::asg_cmd_q_state && bit_ok) begin
                    rep_start = 1'b1;
                    rep_len = 3'h2;
                    rep_b0 = `ASG_CH_0 + {7'h00, pin_s2_q[bitn]};
                    rep_b1 = `ASG_CH_LF;
                    state_d = asg_pkg::asg_st_reply;
                end
            end
            asg_pkg::asg_st_reply: begin
                if (!rep_busy) begin
                    state_d = asg_pkg::asg_st_collect;
                end
            end
            default: state_d = asg_pkg::asg_st_collect;
        endcase
    end

    assign done = (state_q != asg_pkg::asg_st_collect) &&
                  (state_d == asg_pkg::asg_st_collect);

    // State register and registered ready
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= asg_pkg::asg_st_collect;
            rx_ready <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            rx_ready <= (state_d == asg_pkg::asg_st_collect);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Axis target and mode
    always_ff @(posedge clk) begin
        if (rst) begin
            // [RL15] X after reset
            axis_q <= asg_pkg::asg_axis_x;
            multi_q <= 1'b0;
        end else if (ce && fire) begin
            unique case (cmd)
                asg_pkg::asg_cmd_sel_x: begin
                    axis_q <= asg_pkg::asg_axis_x;
                    multi_q <= 1'b0;
                end
                // [RL1] Select Y axis
                asg_pkg::asg_cmd_sel_y: begin
                    axis_q <= asg_pkg::asg_axis_y;
                    multi_q <= 1'b0;
                end
                // [RL2] Select Z axis
                asg_pkg::asg_cmd_sel_z: begin
                    axis_q <= asg_pkg::asg_axis_z;
                    multi_q <= 1'b0;
                end
                asg_pkg::asg_cmd_sel_t: begin
                    axis_q <= asg_pkg::asg_axis_t;
                    multi_q <= 1'b0;
                end
                asg_pkg::asg_cmd_multi: multi_q <= 1'b1;
                default: multi_q <= multi_q;
            endcase
        end
    end

    // [RL13] Bipolar per axis
    always_ff @(posedge clk) begin
        if (rst) begin
            bipolar_q <= `ASG_BIPOLAR_RST;
        end else if (ce && fire && cmd == asg_pkg::asg_cmd_bipolar &&
                     !multi_q) begin
            bipolar_q[axis_q] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output latch
    always_ff @(posedge clk) begin
        if (rst) begin
            // [RL6] Outputs off
            out_q <= `ASG_OUT_RST;
        end else if (ce && fire) begin
            // [RL10] Input bits untouched
            if (cmd == asg_pkg::asg_cmd_high && bit_ok && !oe_n_q[bitn]) begin
                // [RL5] Drive high
                out_q[bitn] <= 1'b1;
            end else if (cmd == asg_pkg::asg_cmd_low && bit_ok &&
                         !oe_n_q[bitn]) begin
                // [RL7] Drive low
                out_q[bitn] <= 1'b0;
            end else if (cmd == asg_pkg::asg_cmd_mask && mask_ok) begin
                // [RL8] Whole mask at once
                out_q <= (arg_q & ~oe_n_q) | (out_q & oe_n_q);
            end
        end
    end

    // Direction register: a set bit in the written value makes an output
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_n_q <= `ASG_OE_N_RST;
        end else if (ce && reg_wr && reg_addr == `ASG_REG_DIR) begin
            oe_n_q <= ~reg_wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [RL12] Wait for input low
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b0;
            wait_bit_q <= 3'h0;
        end else if (ce) begin
            if (fire && cmd == asg_pkg::asg_cmd_wait_low && bit_ok) begin
                wait_q <= 1'b1;
                wait_bit_q <= bitn;
            end else if (wait_q && !pin_s2_q[wait_bit_q]) begin
                wait_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port, data stands one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (ce) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `ASG_REG_DIR: reg_rdata[7:0] <= ~oe_n_q;
                    `ASG_REG_STATUS: begin
                        reg_rdata[`ASG_ST_BIPOLAR_LSB +: 4] <= bipolar_q;
                        reg_rdata[`ASG_ST_AXIS_LSB +: 2] <= axis_q;
                        reg_rdata[`ASG_ST_MULTI_BIT] <= multi_q;
                        reg_rdata[`ASG_ST_WAIT_BIT] <= wait_q;
                        reg_rdata[`ASG_ST_WBIT_LSB +: 3] <= wait_bit_q;
                        reg_rdata[`ASG_ST_VALID_BIT] <= outputs_valid;
                    end
                    `ASG_REG_PINS: begin
                        reg_rdata[7:0] <= pin_s2_q;
                        reg_rdata[`ASG_PN_OUT_LSB +: 8] <= out_q;
                    end
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops
    assign gpio_out = out_q;
    assign gpio_oe_n = oe_n_q;
    assign axis_sel = axis_q;
    assign multi_mode = multi_q;
    assign servo_bipolar = bipolar_q;

    // [RL16] Replies end in line feed
    asg_reply_tx u_reply (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(rep_start),
        .len(rep_len),
        .byte0(rep_b0),
        .byte1(rep_b1),
        .byte2(rep_b2),
        .byte3(rep_b3),
        .busy(rep_busy),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

endmodule // asg_cmd_top

`default_nettype wire

// file: asg_cmd_props.sv
// Purpose: Port assertions for the command block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ps
`default_nettype none

module asg_cmd_props #(
    parameter int GPIO_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Byte streams
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    // Pins and axis state
    input wire logic [GPIO_W-1:0] gpio_out,
    input wire logic [GPIO_W-1:0] gpio_oe_n,
    input wire logic [1:0] axis_sel,
    input wire logic [3:0] servo_bipolar,
    input wire logic outputs_valid
);
    logic [5:0] age_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Cycles since reset release, saturating
    always_ff @(posedge clk) begin
        if (rst) age_q <= 6'h00;
        else if (age_q != 6'h3f) age_q <= age_q + 6'h01;
    end
    // Terminator byte taken
    sequence semi_s;
        rx_valid && rx_ready && rx_data == 8'h3b;
    endsequence
    out_reset_a: assert property (disable iff (1'b0) rst |=>
        gpio_out == '1 && gpio_oe_n == '1) else $error("pins not off");
    axis_reset_a: assert property (disable iff (1'b0) rst |=>
        axis_sel == 2'h0 && servo_bipolar == 4'hf) else $error("axis reset");
    input_keep_a: assert property (gpio_oe_n == $past(gpio_oe_n) |->
        ((gpio_out ^ $past(gpio_out)) & gpio_oe_n) == '0)
        else $error("input bit latch changed");
    semi_stall_a: assert property (semi_s |=> !rx_ready)
        else $error("stream not held");
    axis_cause_a: assert property ($changed(axis_sel) |->
        $past(rst) || $past(rx_valid && rx_ready && rx_data == 8'h3b, 2))
        else $error("axis changed unasked");
    reply_end_a: assert property ($fell(tx_valid) && !$past(rst) |->
        $past(tx_data) == 8'h0a) else $error("reply not ended by LF");
    settle_low_a: assert property (age_q < 6'd38 |-> !outputs_valid)
        else $error("outputs flagged valid early");
    settle_high_a: assert property (age_q > 6'd42 |-> outputs_valid)
        else $error("outputs never flagged valid");
endmodule // asg_cmd_props

bind asg_cmd_top asg_cmd_props #(.GPIO_W(GPIO_W)) u_props (
    .clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .axis_sel(axis_sel),
    .servo_bipolar(servo_bipolar), .outputs_valid(outputs_valid));
`default_nettype wire

// file: asg_host.sv
// Purpose: Host model sending commands and collecting replies.
// Assumes: Valid/ready byte streams of the command block.
// Notes:   Idle data shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none

module asg_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // Reply stream
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic [7:0] rq[$];
    ////////////////////////////////////////
    // Idle stream at time zero
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // Sink readiness, halved when slow
    always @(posedge clk) tx_ready <= !rst && (!slow || !tx_ready);
    // Reply capture
    always @(posedge clk) if (tx_valid && tx_ready) rq.push_back(tx_data);
    task automatic send(input string s);
        @(posedge clk);
        for (int i = 0; i < s.len(); i++) begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_data <= ~s[s.len()-1];
    endtask
endmodule // asg_host
`default_nettype wire

// file: tb_asg_cmd_top.sv
// Purpose: Self-checking bench for axis select and GPIO commands.
// Assumes: Host model on the streams; ce held high.
// Notes:   Register port sets direction and reads status.
`timescale 1ns/1ps
`default_nettype none

module tb_asg_cmd_top;
    logic clk, rst, rx_valid, rx_ready, tx_valid, tx_ready, reg_wr, reg_rd;
    logic [7:0] rx_data, tx_data, gpio_in, gpio_out, gpio_oe_n;
    logic [1:0] axis_sel;
    logic multi_mode, outputs_valid;
    logic [3:0] servo_bipolar, reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    int failures = 0;
    int n_tests = 0;
    ////////////////////////////////////////
    asg_cmd_top dut (.clk(clk), .rst(rst), .ce(1'b1), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .axis_sel(axis_sel),
        .multi_mode(multi_mode), .servo_bipolar(servo_bipolar),
        .outputs_valid(outputs_valid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    asg_host host (.clk(clk), .rst(rst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask
    task wait_rdy;
        for (int k = 0; k == 0 || (rx_ready !== 1'b1 && k < 60); k++)
            @(posedge clk);
    endtask
    task cmd(input string c);
        host.send(c);
        wait_rdy;
    endtask
    task query(input string c, input string e);
        host.rq.delete();
        cmd(c);
        chk(host.rq.size(), e.len());
        for (int i = 0; i < e.len(); i++) chk(host.rq[i], e[i]);
    endtask
    task t_reset;
        chk(gpio_out, 8'hff);
        chk({axis_sel, servo_bipolar}, 6'h0f);
        chk(outputs_valid, 1'b0);
        repeat (45) @(posedge clk);
        chk(outputs_valid, 1'b1);
        $display("test reset done");
    endtask
    task t_axis;
        static string s[4] = '{"AY;", "az;", "AT;", "AX;"};
        for (int i = 0; i < 4; i++) begin
            cmd(s[i]);
            chk(axis_sel, (i + 1) % 4);
        end
        cmd("AY;");
        rd(4'h4);
        chk(v[5:4], 2'h1);
        cmd("AM;");
        cmd("BI;");
        chk({multi_mode, servo_bipolar}, 5'h1f);
        cmd("AX;");
        chk(multi_mode, 1'b0);
        rd(4'hc);
        chk(v, 32'h0);
        $display("test axis done");
    endtask
    task t_gpio;
        query("?BD2;", "io0\n");
        wr(4'h0, 32'h3c);
        query("?BD2;", "io1\n");
        cmd("BL4;");
        chk(gpio_out, 8'hef);
        cmd("BH4;");
        chk(gpio_out, 8'hff);
        cmd("BL0;");
        chk(gpio_out, 8'hff);
        cmd("BS71;");
        chk(gpio_out, 8'((8'h71 & 8'h3c) | ~8'h3c));
        $display("test gpio done");
    endtask
    task t_pins;
        host.slow <= 1'b1;
        gpio_in <= 8'h40;
        query("?BS6;", "1\n");
        gpio_in <= 8'h02;
        query("?BS6;", "0\n");
        host.slow <= 1'b0;
        fork
            begin
                host.send("BW1;");
                host.send("AY;");
                host.send("BL5;");
            end
        join_none
        repeat (30) @(posedge clk);
        chk(gpio_out, 8'hf3);
        chk(axis_sel, 2'h1);
        gpio_in <= 8'h00;
        for (int k = 0; k < 30 && gpio_out[5] !== 1'b0; k++) @(posedge clk);
        chk(gpio_out, 8'hd3);
        wait_rdy;
        $display("test pins done");
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test;
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        gpio_in = 8'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_axis;
        t_gpio;
        t_pins;
        end_of_test;
    end
endmodule // tb_asg_cmd_top
`default_nettype wire
